// ---- common/lps_defines.vh ----
/*
 * Constants for the LCD panel power sequencer: APB register map, field
 * positions, reset values and timing counts.
 * Assumes a 10 MHz core clock; every cycle count but the link idle count is derived from it here.
 */
`ifndef LPS_DEFINES_VH
`define LPS_DEFINES_VH

// register byte addresses
`define LPS_ADDR_CTRL 8'h00
`define LPS_ADDR_DIV 8'h04
`define LPS_ADDR_STEP 8'h08
`define LPS_ADDR_STAT 8'h0C

// field positions
`define LPS_CTRL_RUN 0
`define LPS_STEP_N1_LSB 0
`define LPS_STEP_N1_MSB 3
`define LPS_STEP_N2_LSB 4
`define LPS_STEP_N2_MSB 7
`define LPS_STAT_LINKBITS_LSB 12
`define LPS_STAT_LINKBITS_MSB 15

// reset values
`define LPS_DIV_RST 8'h01
`define LPS_STEP_RST 4'h0
`define LPS_ZERO32 32'h0000_0000

// timing: clock period and derived counts
`define LPS_CLK_NS 100
`define LPS_US_NS 1000
`define LPS_US_CYC (`LPS_US_NS / `LPS_CLK_NS)
`define LPS_PLL_RST_US 10
`define LPS_PLL_RST_CYC \
    ((`LPS_PLL_RST_US * `LPS_US_NS + `LPS_CLK_NS - 1) / `LPS_CLK_NS)
`define LPS_PLL_LOCK_US 750
`define LPS_PLL_LOCK_CYC ((`LPS_PLL_LOCK_US * `LPS_US_NS) / `LPS_CLK_NS)

// link clock considered stopped after this many cycles without a rise
`define LPS_LINK_IDLE_CYC 5'h10

// serial bits per differential clock period
`define LPS_BITS_PER_CLK 4'h7

`endif

// ---- rtl/lps_sequencer.v ----
/*
 * LCD panel power sequencer with APB register access.
 * Drives panel digital power, LVDS link enable, transmitter PLL reset and
 * backlight in order; samples the transmitter clock from outside.
 * Assumes a 10 MHz CLOCK, synchronous active-low RESETN, a zero-wait APB
 * master, and a serializer outside that uses the link enable.
 */
`default_nettype none
`include "lps_defines.vh"

module lps_sequencer #(
    parameter LOCK_CYC = `LPS_PLL_LOCK_CYC,
    parameter PLL_RST_CYC = `LPS_PLL_RST_CYC
) (
    input wire CLOCK,
    input wire RESETN,
    input wire CE,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire LINK_CLK,
    output reg PANEL_DIGITAL_POWER_ON,
    output reg LVDS_LINK_EN,
    output reg LVDS_PLL_RESET,
    output reg PANEL_BACKLIGHT_ON
);
    localparam S_OFF = 3'h0;
    localparam S_UP_DIG = 3'h1;
    localparam S_UP_LINK = 3'h2;
    localparam S_ON = 3'h3;
    localparam S_DN_BL = 3'h4;
    localparam S_DN_LINK = 3'h5;
    localparam [31:0] CYC_RST_W = PLL_RST_CYC;
    localparam [31:0] CYC_DONE_W = PLL_RST_CYC + LOCK_CYC;
    // cut to the 14-bit pll timer on purpose; the defaults fit with room
    localparam [13:0] CYC_RST = CYC_RST_W[13:0];
    localparam [13:0] CYC_DONE = CYC_DONE_W[13:0];

    reg run_reg;
    reg [7:0] div_reg;
    reg [3:0] n1_reg;
    reg [3:0] n2_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [3:0] step_cnt_reg;
    reg [13:0] cyc_reg;
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    reg link_lvl_reg;
    reg [4:0] idle_reg;
    reg [3:0] step_n;
    wire tick;
    wire step_met;
    wire lock_ok;
    wire link_alive;
    wire link_rise;
    wire wr_en;
    wire rd_setup;
    wire addr_ok;

    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `LPS_ADDR_CTRL) || (a == `LPS_ADDR_DIV) ||
                (a == `LPS_ADDR_STEP) || (a == `LPS_ADDR_STAT);
        end
    endfunction

    // zero-wait slave: every access completes in its first access cycle
    assign PREADY = 1'b1;
    assign addr_ok = is_mapped(PADDR);
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    assign wr_en = PSEL && PENABLE && PWRITE && addr_ok && CE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;

    // register writes; a write of zero to the divider runs as one
    always @(posedge CLOCK) begin
        if (!RESETN) begin
            run_reg <= 1'b0;
            div_reg <= `LPS_DIV_RST;
            n1_reg <= `LPS_STEP_RST;
            n2_reg <= `LPS_STEP_RST;
        end else if (wr_en) begin
            if (PADDR == `LPS_ADDR_CTRL)
                run_reg <= PWDATA[`LPS_CTRL_RUN];
            if (PADDR == `LPS_ADDR_DIV)
                div_reg <= PWDATA[7:0];
            if (PADDR == `LPS_ADDR_STEP) begin
                n1_reg <= PWDATA[`LPS_STEP_N1_MSB:`LPS_STEP_N1_LSB];
                n2_reg <= PWDATA[`LPS_STEP_N2_MSB:`LPS_STEP_N2_LSB];
            end
        end
    end

    // read data captured in the setup cycle, held through the access
    always @(posedge CLOCK) begin
        if (!RESETN) begin
            PRDATA <= `LPS_ZERO32;
        end else if (CE && rd_setup) begin
            PRDATA <= `LPS_ZERO32;
            case (PADDR)
                `LPS_ADDR_CTRL: PRDATA[`LPS_CTRL_RUN] <= run_reg;
                `LPS_ADDR_DIV: PRDATA[7:0] <= div_reg;
                `LPS_ADDR_STEP: PRDATA[7:0] <= {n2_reg, n1_reg};
                `LPS_ADDR_STAT: begin
                    PRDATA[2:0] <= state_reg;
                    PRDATA[3] <= PANEL_DIGITAL_POWER_ON;
                    PRDATA[4] <= LVDS_LINK_EN;
                    PRDATA[5] <= PANEL_BACKLIGHT_ON;
                    PRDATA[6] <= LVDS_PLL_RESET;
                    PRDATA[7] <= lock_ok;
                    PRDATA[8] <= link_alive;
                    // serializer ratio is fixed; software can read it
                    PRDATA[`LPS_STAT_LINKBITS_MSB:`LPS_STAT_LINKBITS_LSB] <=
                        `LPS_BITS_PER_CLK;
                end
                default: PRDATA <= `LPS_ZERO32;
            endcase
        end
    end

    // link clock sampler; a level counts once stages two and three agree
    always @(posedge CLOCK) begin
        if (!RESETN) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            link_lvl_reg <= 1'b0;
            idle_reg <= `LPS_LINK_IDLE_CYC;
        end else if (CE) begin
            s1_reg <= LINK_CLK;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg)
                link_lvl_reg <= s3_reg;
            if (link_rise)
                idle_reg <= 5'h00;
            else if (!link_alive)
                idle_reg <= idle_reg;
            else
                idle_reg <= idle_reg + 5'h01;
        end
    end

    assign link_rise = (s2_reg == s3_reg) && s3_reg && !link_lvl_reg;
    assign link_alive = (idle_reg < `LPS_LINK_IDLE_CYC);

    lps_timebase u_timebase (
        .clk(CLOCK),
        .rst_n(RESETN),
        .ce(CE),
        .clr(state_next != state_reg),
        .div(div_reg),
        .tick(tick)
    );

    // step count for the current phase: N1 next to power, N2 next to light
    always @* begin
        case (state_reg)
            S_UP_DIG: step_n = n1_reg;
            S_DN_LINK: step_n = n1_reg;
            S_UP_LINK: step_n = n2_reg;
            S_DN_BL: step_n = n2_reg;
            default: step_n = 4'h0;
        endcase
    end

    // a zero count still needs one tick, so the phase ends at the next tick
    assign step_met = (step_cnt_reg != 4'h0) &&
        (step_cnt_reg >= step_n);
    assign lock_ok = (cyc_reg >= CYC_DONE);

    // phase sequencing; requests during a rising phase reverse from there
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_OFF: if (run_reg) state_next = S_UP_DIG;
            S_UP_DIG: begin
                if (!run_reg)
                    state_next = S_DN_LINK;
                else if (step_met && lock_ok && link_alive)
                    state_next = S_UP_LINK;
            end
            S_UP_LINK: begin
                if (!run_reg)
                    state_next = S_DN_BL;
                else if (step_met)
                    state_next = S_ON;
            end
            S_ON: if (!run_reg) state_next = S_DN_BL;
            S_DN_BL: if (step_met) state_next = S_DN_LINK;
            S_DN_LINK: if (step_met) state_next = S_OFF;
            default: state_next = S_OFF;
        endcase
    end

    // state, step tick counter and PLL cycle counter
    always @(posedge CLOCK) begin
        if (!RESETN) begin
            state_reg <= S_OFF;
            step_cnt_reg <= 4'h0;
            cyc_reg <= 14'h0000;
        end else if (CE) begin
            state_reg <= state_next;
            if (state_next != state_reg)
                step_cnt_reg <= 4'h0;
            else if (tick && step_cnt_reg != 4'hF)
                step_cnt_reg <= step_cnt_reg + 4'h1;
            // pll timer only runs while power is up and link not yet on
            if (state_next != S_UP_DIG)
                cyc_reg <= 14'h0000;
            else if (!lock_ok)
                cyc_reg <= cyc_reg + 14'h0001;
        end
    end

    // outputs registered from the next state so they move with the state
    always @(posedge CLOCK) begin
        if (!RESETN) begin
            PANEL_DIGITAL_POWER_ON <= 1'b0;
            LVDS_LINK_EN <= 1'b0;
            LVDS_PLL_RESET <= 1'b1;
            PANEL_BACKLIGHT_ON <= 1'b0;
        end else if (CE) begin
            PANEL_DIGITAL_POWER_ON <= (state_next != S_OFF);
            LVDS_LINK_EN <= (state_next == S_UP_LINK) ||
                (state_next == S_ON) || (state_next == S_DN_BL);
            PANEL_BACKLIGHT_ON <= (state_next == S_ON);
            // reset held for the first PLL_RST_CYC cycles of power-up
            LVDS_PLL_RESET <= (state_next == S_OFF) ||
                (state_next == S_DN_LINK) ||
                ((state_next == S_UP_DIG) &&
                 (state_reg != S_UP_DIG || cyc_reg < CYC_RST));
        end
    end
endmodule
`default_nettype wire

// ---- rtl/lps_timebase.v ----
/*
 * Timebase for the panel power sequencer: a microsecond prescaler and a
 * divider by M that yields one tick every M microseconds.
 * Assumes the 10 MHz core clock; clr restarts the timebase at phase start.
 */
`default_nettype none
`include "lps_defines.vh"

module lps_timebase #(
    parameter US_CYC = `LPS_US_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire clr,
    input wire [7:0] div,
    output reg tick
);
    reg [7:0] us_cnt_reg;
    reg [7:0] div_cnt_reg;
    wire us_end;
    wire [7:0] div_eff;

    // a divider of zero is outside the legal range; treat it as one
    assign div_eff = (div == 8'h00) ? 8'h01 : div;
    assign us_end = (us_cnt_reg == US_CYC[7:0] - 8'h01);

    // prescaler and divider, restarted by clr so each phase is whole ticks
    always @(posedge clk) begin
        if (!rst_n) begin
            us_cnt_reg <= 8'h00;
            div_cnt_reg <= 8'h00;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= 1'b0;
            if (clr) begin
                us_cnt_reg <= 8'h00;
                div_cnt_reg <= 8'h00;
            end else if (us_end) begin
                us_cnt_reg <= 8'h00;
                if (div_cnt_reg == div_eff - 8'h01) begin
                    div_cnt_reg <= 8'h00;
                    tick <= 1'b1;
                end else begin
                    div_cnt_reg <= div_cnt_reg + 8'h01;
                end
            end else begin
                us_cnt_reg <= us_cnt_reg + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/lcd_panel_power_sequencer_tb.sv ----
/* Self-checking bench for lps_sequencer: registers over APB, power
   up/down phase delays, lock wait, stalled link clock and abort.
   Assumes lps_link_model and the bound checker are part of the build. */
`default_nettype none
`include "lps_defines.vh"
module lcd_panel_power_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LOCK = 20;
    localparam int PRST = 4;
    logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, lrun = 1'b1, err;
    logic ce = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    wire [31:0] prdata;
    wire pready, pslverr, lclk, digon, link_en, pll_rst, blon;
    int n_errors = 0, tests_run = 0, m, n1, n2, cyc;
    lps_sequencer #(.LOCK_CYC(LOCK), .PLL_RST_CYC(PRST)) uut (
        .CLOCK(clock), .RESETN(resetn), .CE(ce), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .LINK_CLK(lclk),
        .PANEL_DIGITAL_POWER_ON(digon), .LVDS_LINK_EN(link_en),
        .LVDS_PLL_RESET(pll_rst), .PANEL_BACKLIGHT_ON(blon));
    lps_link_model lm (.run(lrun), .link_clk(lclk));
    always #50 clock = ~clock;
    task automatic chk(input logic [31:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one APB transfer; answer taken at the edge that sees pready
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_sig(input int which, input logic v);
        cyc = 0;
        while ((which == 0 ? digon : which == 1 ? link_en : blon) !== v) begin
            @(posedge clock);
            cyc++;
        end
    endtask
    function automatic logic [31:0] in_win(int c, int mm, int nn);
        return c >= mm * nn * 10 && c <= mm * (nn == 0 ? 1 : nn) * 10 + 3;
    endfunction
    task automatic run_seq(input bit stall);
        apb(1, `LPS_ADDR_DIV, m);
        apb(1, `LPS_ADDR_STEP, n2 * 16 + n1);
        apb(0, `LPS_ADDR_STEP, 0);
        chk(rd[7:0], n2 * 16 + n1, "step readback");
        apb(0, `LPS_ADDR_DIV, 0);
        chk(rd[7:0], m, "div readback");
        lrun <= !stall;
        apb(1, `LPS_ADDR_CTRL, 1);
        wait_sig(0, 1);
        if (stall) begin
            repeat (300) @(posedge clock);
            chk(link_en, 1'b0, "link up without clock");
            lrun <= 1'b1;
        end
        wait_sig(1, 1);
        cyc += stall ? 300 : 0;
        chk(cyc >= m * n1 * 10 && cyc >= PRST + LOCK, 1, "t1");
        wait_sig(2, 1);
        chk(in_win(cyc, m, n2), 1, "t2");
        apb(0, `LPS_ADDR_STAT, 0);
        chk(rd[5:3], 3'b111, "all on");
        // clock enable low: state must freeze and the write must be dropped
        ce <= 1'b0;
        apb(1, `LPS_ADDR_CTRL, 0);
        repeat (30) @(posedge clock);
        chk({digon, link_en, blon}, 3'b111, "frozen while disabled");
        ce <= 1'b1;
        apb(0, `LPS_ADDR_CTRL, 0);
        chk(rd[0], 1'b1, "write dropped while disabled");
        apb(1, `LPS_ADDR_CTRL, 0);
        wait_sig(2, 0);
        wait_sig(1, 0);
        chk(in_win(cyc, m, n2), 1, "t3");
        chk(pll_rst, 1'b1, "pll reset back on");
        wait_sig(0, 0);
        chk(in_win(cyc, m, n1), 1, "t4");
        $display("test done m=%0d n1=%0d n2=%0d", m, n1, n2);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(3783));
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        apb(0, `LPS_ADDR_DIV, 0);
        chk(rd, 32'h0000_0001, "div reset");
        apb(0, `LPS_ADDR_STAT, 0);
        chk(rd[15:12], 4'h7, "bits per clock");
        apb(1, 8'h40, 32'hFFFF_FFFF);
        chk(err, 1'b1, "unmapped write");
        apb(0, 8'h40, 0);
        chk(err, 1'b1, "unmapped read error");
        chk(rd, 32'h0000_0000, "unmapped read data");
        $display("test done registers");
        // both ends of M and N, then random mixes
        for (int i = 0; i < 6; i++) begin
            m = i == 0 ? 1 : i == 1 ? 255 : $urandom_range(1, 6);
            n1 = i == 0 ? 0 : i == 1 ? 1 : i == 2 ? 15 : $urandom_range(0, 15);
            n2 = i < 2 ? 0 : i == 2 ? 15 : $urandom_range(0, 15);
            run_seq(i == 3);
        end
        // abort in the first phase: power must drop with no link
        apb(1, `LPS_ADDR_CTRL, 1);
        apb(1, `LPS_ADDR_CTRL, 0);
        wait_sig(0, 0);
        chk(link_en, 1'b0, "abort keeps link off");
        $display("test done abort");
        // abort once the link runs: the backlight must never come on
        apb(1, `LPS_ADDR_CTRL, 1);
        wait_sig(1, 1);
        apb(1, `LPS_ADDR_CTRL, 0);
        chk(blon, 1'b0, "no backlight after link abort");
        wait_sig(0, 0);
        chk({link_en, blon, pll_rst}, 3'b001, "abort ends off");
        $display("test done link abort");
        finish_test();
    end
    initial begin
        repeat (90000) @(posedge clock);
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire

// ---- tb/lps_link_model.sv ----
/* Transmitter clock source seen by the sequencer.
   Assumes the bench enables it; parks low when disabled. */
`default_nettype none
module lps_link_model (
    input wire logic run,
    output logic link_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_q = 1'b0;
    assign link_clk = clk_q;
    // 800 ns period; stops low so a dead link is really seen as dead
    always begin
        #400;
        clk_q = run ? ~clk_q : 1'b0;
    end
endmodule
`default_nettype wire

// ---- tb/lps_seq_chk.sv ----
/* Checker for the panel power sequencer: phase delays, PLL reset hold
   and lock wait, judged at the top ports only.
   Assumes APB writes land only at a mapped address with CE high. */
`default_nettype none
`include "lps_defines.vh"
module lps_seq_chk #(
    parameter LOCK_CYC = 7500,
    parameter PLL_RST_CYC = 100
) (
    input wire CLOCK,
    input wire RESETN,
    input wire CE,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire LINK_CLK,
    input wire PANEL_DIGITAL_POWER_ON,
    input wire LVDS_LINK_EN,
    input wire LVDS_PLL_RESET,
    input wire PANEL_BACKLIGHT_ON
);
    logic [7:0] m_reg, n_reg;
    logic [15:0] dig_cnt, lnk_cnt, bl_cnt, rst_cnt;
    wire wr = PSEL && PENABLE && PWRITE && CE;
    wire [3:0] n2_min = (n_reg[7:4] == 4'h0) ? 4'h1 : n_reg[7:4];
    wire [15:0] t1 = m_reg * n_reg[3:0] * 16'h000A;
    wire [15:0] t2 = m_reg * n_reg[7:4] * 16'h000A;
    wire [15:0] t2_max = m_reg * n2_min * 16'h000A + 16'h0003;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    // delay since last change: 1 on the edge that sees it, saturating
    function automatic logic [15:0] nxt(input logic [15:0] c, input logic ch);
        return (ch || !RESETN) ? 16'h0001 : c + {15'h0000, ~&c};
    endfunction
    // shadow of the timing fields so delays can be judged at the pins
    always @(posedge CLOCK) begin
        if (!RESETN) begin
            m_reg <= `LPS_DIV_RST;
            n_reg <= 8'h00;
        end else if (wr && PADDR == `LPS_ADDR_DIV) begin
            m_reg <= PWDATA[7:0];
        end else if (wr && PADDR == `LPS_ADDR_STEP) begin
            n_reg <= PWDATA[7:0];
        end
    end
    // one age counter per sequenced output: power, link, backlight and pll reset
    always @(posedge CLOCK) begin
        dig_cnt <= nxt(dig_cnt, $changed(PANEL_DIGITAL_POWER_ON));
        lnk_cnt <= nxt(lnk_cnt, $changed(LVDS_LINK_EN));
        bl_cnt <= nxt(bl_cnt, $changed(PANEL_BACKLIGHT_ON));
        rst_cnt <= nxt(rst_cnt, $changed(LVDS_PLL_RESET));
    end
    sequence s_link_up;
        $rose(LVDS_LINK_EN);
    endsequence
    sequence s_bl_up;
        $rose(PANEL_BACKLIGHT_ON);
    endsequence
    a_link_has_power: assert property (
        LVDS_LINK_EN |-> PANEL_DIGITAL_POWER_ON)
        else $error("link active without panel power");
    a_bl_has_link: assert property (
        PANEL_BACKLIGHT_ON |-> LVDS_LINK_EN && !LVDS_PLL_RESET)
        else $error("backlight on without running link");
    a_link_delay: assert property (s_link_up |-> dig_cnt >= t1)
        else $error("link started too early after power");
    a_bl_delay: assert property (
        s_bl_up |-> lnk_cnt >= t2 && lnk_cnt <= t2_max)
        else $error("backlight delay out of window");
    a_link_stop: assert property (
        $fell(LVDS_LINK_EN) |-> bl_cnt >= t2 && LVDS_PLL_RESET)
        else $error("link stopped too early after backlight");
    a_power_off: assert property (
        $fell(PANEL_DIGITAL_POWER_ON) |-> lnk_cnt >= t1 && !LVDS_LINK_EN)
        else $error("power dropped too early after link");
    a_pll_hold: assert property (
        $fell(LVDS_PLL_RESET) |-> rst_cnt >= PLL_RST_CYC)
        else $error("pll reset released too soon");
    a_lock_wait: assert property (
        s_link_up |-> rst_cnt >= LOCK_CYC && !LVDS_PLL_RESET)
        else $error("link started before lock time");
endmodule
bind lps_sequencer lps_seq_chk #(.LOCK_CYC(LOCK_CYC),
    .PLL_RST_CYC(PLL_RST_CYC)) chk (.*);
`default_nettype wire
